// file: core/pc_paging_stack_indirect_addr.sv
// Program counter paging, two-level return stack and indirect addressing
// Summary of operation
// [R1] Page overflow continues in next page, bits kept
// [R2] Jump, call, latch write use page bits
// [R3] Reset sets all counter bits to one
// [R4] Reset clears the page preselect bits
// [R5] Two stack entries, full counter width
// [R6] Call copies entry one down, pushes pc+1
// [R7] Deeper nesting silently drops oldest address
// [R8] Return pops entry one, entry two stays
// [R9] Return loads accumulator with literal
// [R10] Indirect location redirects through pointer
// [R11] Pointer zero reads return zero
// [R12] Pointer zero writes store nothing
// [R13] Pointer five bits unbanked, seven banked
// [R14] Low pointer bits select bank location
// [R15] Unbanked upper pointer bits read ones
// [R16] Upper pointer bits select one of four banks
// [R17] Low sixteen locations alias bank zero
// [R18] Counter advances by one each cycle; the code advances it only on each executed instruction
// [R19] Jump loads bits eight to zero
// [R20] Call or latch write clears bit eight
// [R21] Stack undefined at reset, bare return allowed
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module pc_paging_stack_indirect_addr
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [10:0]      pc_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {W_IDLE = 2'b00, W_RESP = 2'b01} wr_state_e;

  wr_state_e   wst_q, wst_d;
  logic        aw_have_q, w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [10:0] pc_q;
  logic [1:0]  page_preselect_bits_q;
  logic [10:0] stack_q [2];
  logic [6:0]  indirect_pointer_q;
  logic [7:0]  acc_q;
  logic [1:0]  variant_q;
  logic [7:0]  data_in_q;
  logic [7:0]  ind_rdata_q;
  logic        awready_q, wready_q, bvalid_q, arready_q;
  logic        aw_have_d, w_have_d;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  logic        aw_take, w_take, wr_go, ar_take;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic        wsel_ctrl, wsel_instr, wsel_page, wsel_ptr, wsel_data, wr_hit;
  logic        rd_hit;

  assign aw_take = s_axi_awvalid && !aw_have_q && (wst_q == W_IDLE);
  assign w_take  = s_axi_wvalid && !w_have_q && (wst_q == W_IDLE);
  assign wr_go   = (wst_q == W_IDLE) && (aw_have_q || aw_take) && (w_have_q || w_take);
  assign wa      = aw_have_q ? aw_addr_q : s_axi_awaddr;
  assign wd      = w_have_q ? w_data_q : s_axi_wdata;
  // Only the low strobe lane is checked; an unset low lane drops the write
  assign wsel_ctrl  = wr_go && (wa == seq_pkg::ADDR_CTRL);
  assign wsel_instr = wr_go && (wa == seq_pkg::ADDR_INSTR);
  assign wsel_page  = wr_go && (wa == seq_pkg::ADDR_PAGE);
  assign wsel_ptr   = wr_go && (wa == seq_pkg::ADDR_PTR);
  assign wsel_data  = wr_go && (wa == seq_pkg::ADDR_DATA);
  assign wr_hit     = wsel_ctrl | wsel_instr | wsel_page | wsel_ptr | wsel_data;

  logic lane0;
  assign lane0 = (w_have_q ? w_strb_q[0] : s_axi_wstrb[0]);

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Instruction word: [26:24] operation, [10:0] operand
  logic        exec;
  logic [2:0]  op;
  logic [10:0] opnd;
  assign exec = wsel_instr && lane0;
  assign op   = wd[26:24];
  assign opnd = wd[10:0];

  logic is_jump, is_call, is_ret, is_pcl, is_iw, is_ir;
  assign is_jump = exec && (op == seq_pkg::OP_JUMP);
  assign is_call = exec && (op == seq_pkg::OP_CALL);
  assign is_ret  = exec && (op == seq_pkg::OP_RETLIT);
  assign is_pcl  = exec && (op == seq_pkg::OP_PCL_WRITE);
  assign is_iw   = exec && (op == seq_pkg::OP_IND_WRITE);
  assign is_ir   = exec && (op == seq_pkg::OP_IND_READ);

  // ----------------------------------------------------------------
  // Program counter next value
  // ----------------------------------------------------------------
  // Width mask per variant: 9, 10 or 11 counter bits
  logic [10:0] pc_mask, pc_inc, pc_jump, pc_short, pc_next;
  assign pc_mask  = (variant_q == seq_pkg::VAR_PC9_UNBANKED)  ? 11'h1ff :
                    (variant_q == seq_pkg::VAR_PC10_UNBANKED) ? 11'h3ff : 11'h7ff;
  // Plain carry across the page boundary; page bits left alone
  assign pc_inc   = (pc_q + 11'h001) & pc_mask;                         // [R1] [R18]
  assign pc_jump  = {page_preselect_bits_q, opnd[8:0]} & pc_mask;       // [R2] [R19]
  assign pc_short = {page_preselect_bits_q, 1'b0, opnd[7:0]} & pc_mask; // [R2] [R20]
  assign pc_next  = is_jump ? pc_jump :
                    (is_call || is_pcl) ? pc_short :
                    is_ret ? (stack_q[0] & pc_mask) :                   // [R8] [R21]
                    pc_inc;

  // ----------------------------------------------------------------
  // Pointer view
  // ----------------------------------------------------------------
  logic banked;
  logic [6:0] ptr_view;
  assign banked   = (variant_q == seq_pkg::VAR_PC11_BANKED);
  // Unbanked parts hold only five bits, the top pair reads as ones
  assign ptr_view = banked ? indirect_pointer_q :
                    {seq_pkg::UNBANKED_TOP, indirect_pointer_q[4:0]};   // [R13] [R15]

  logic [7:0] mem_rdata;
  seq_data_mem u_mem
  (
    .aclk   (aclk),
    .we     (is_iw),
    .ptr    (ptr_view),
    .banked (banked),
    .wdata  (data_in_q),
    .rdata  (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Write response handshake
  // ----------------------------------------------------------------
  always_comb
  begin
    wst_d = wst_q;
    case (wst_q)
      W_IDLE:  if (wr_go) wst_d = W_RESP;
      W_RESP:  if (s_axi_bready) wst_d = W_IDLE;
      default: wst_d = W_IDLE;
    endcase
  end

  // Next holding state, shared by the capture flops and the readies
  assign aw_have_d = wr_go ? 1'b0 : (aw_have_q | aw_take);
  assign w_have_d  = wr_go ? 1'b0 : (w_have_q | w_take);

  // Hold whichever half of the write arrives first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wst_q     <= W_IDLE;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bresp_q   <= seq_pkg::RESP_OKAY;
    end
    else
    begin
      wst_q     <= wst_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      if (aw_take) aw_addr_q <= s_axi_awaddr;
      if (w_take) w_data_q <= s_axi_wdata;
      if (w_take) w_strb_q <= s_axi_wstrb;
      if (wr_go) bresp_q <= wr_hit ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
    end
  end

  // Readies and response valid get flops of their own, fed from the next
  // state, so the bus sees no logic between a flop and a pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
    end
    else
    begin
      awready_q <= !aw_have_d && (wst_d == W_IDLE);
      wready_q  <= !w_have_d && (wst_d == W_IDLE);
      bvalid_q  <= (wst_d == W_RESP);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ----------------------------------------------------------------
  // Core sequencing registers
  // ----------------------------------------------------------------
  // Counter steps only when an instruction is executed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_q                  <= seq_pkg::PC_RESET;    // [R3]
      page_preselect_bits_q <= seq_pkg::PAGE_RESET;  // [R4]
      variant_q             <= seq_pkg::VAR_RESET;
      indirect_pointer_q    <= seq_pkg::PTR_RESET;
      acc_q                 <= seq_pkg::ACC_RESET;
      data_in_q             <= 8'h00;
      ind_rdata_q           <= 8'h00;
    end
    else
    begin
      if (exec) pc_q <= pc_next;                     // [R18]
      if (wsel_page && lane0) page_preselect_bits_q <= wd[1:0];
      if (wsel_ctrl && lane0) variant_q <= wd[1:0];
      if (wsel_ptr && lane0) indirect_pointer_q <= wd[6:0];
      if (wsel_data && lane0) data_in_q <= wd[7:0];
      if (is_ret) acc_q <= opnd[7:0];                // [R9]
      if (is_ir) ind_rdata_q <= mem_rdata;           // [R10] [R11]
    end
  end

  // Stack has no reset; entry one is undefined until the first call, entry two until the second
  always_ff @(posedge aclk)
  begin
    if (is_call)
    begin
      stack_q[1] <= stack_q[0];                      // [R6] [R7]
      stack_q[0] <= pc_inc;                          // [R5] [R6]
    end
    else if (is_ret)
      stack_q[0] <= stack_q[1];                      // [R8]
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  logic [7:0]  ra;
  assign ra      = s_axi_araddr;
  assign ar_take = s_axi_arvalid && !rvalid_q;
  assign rd_hit  = (ra == seq_pkg::ADDR_CTRL) || (ra == seq_pkg::ADDR_INSTR) ||
                   (ra == seq_pkg::ADDR_PC) || (ra == seq_pkg::ADDR_PAGE) ||
                   (ra == seq_pkg::ADDR_PTR) || (ra == seq_pkg::ADDR_ACC) ||
                   (ra == seq_pkg::ADDR_STACK1) || (ra == seq_pkg::ADDR_STACK2) ||
                   (ra == seq_pkg::ADDR_DATA) || (ra == seq_pkg::ADDR_RDATA);
  assign rmux    = (ra == seq_pkg::ADDR_CTRL)   ? {30'h0, variant_q} :
                   (ra == seq_pkg::ADDR_PC)     ? {21'h0, pc_q} :
                   (ra == seq_pkg::ADDR_PAGE)   ? {30'h0, page_preselect_bits_q} :
                   (ra == seq_pkg::ADDR_PTR)    ? {25'h0, ptr_view} :       // [R15]
                   (ra == seq_pkg::ADDR_ACC)    ? {24'h0, acc_q} :
                   (ra == seq_pkg::ADDR_STACK1) ? {21'h0, stack_q[0] & pc_mask} :
                   (ra == seq_pkg::ADDR_STACK2) ? {21'h0, stack_q[1] & pc_mask} :
                   (ra == seq_pkg::ADDR_DATA)   ? {24'h0, data_in_q} :
                   (ra == seq_pkg::ADDR_RDATA)  ? {24'h0, ind_rdata_q} :
                   32'h0000_0000;

  // One read at a time; address accepted and answered next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
      rdata_q   <= 32'h0000_0000;
      rresp_q  <= seq_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q  <= 1'b1;
      arready_q <= 1'b0;
      rdata_q  <= rmux;
      rresp_q  <= rd_hit ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Registered copy of the counter for the fetch side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pc_out <= seq_pkg::PC_RESET;
    else
      pc_out <= exec ? pc_next : pc_q;
  end

endmodule // pc_paging_stack_indirect_addr

// file: core/seq_data_mem.sv
// Banked data memory reached through the indirect pointer
`timescale 1ns/1ps
module seq_data_mem
(
  input  wire logic       aclk,
  input  wire logic       we,
  input  wire logic [6:0] ptr,
  input  wire logic       banked,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  logic [7:0] mem [0:127];
  logic [6:0] phys;
  logic       is_ind;

  // ----------------------------------------------------------------
  // Address mapping
  // ----------------------------------------------------------------
  // Low half of every bank folds onto bank zero
  assign phys   = (!banked || !ptr[seq_pkg::ALIAS_POS]) ?
                  {2'h0, ptr[4:0]} : ptr;                       // [R14] [R16] [R17]
  assign is_ind = (ptr[4:0] == seq_pkg::IND_ADDR);
  // Indirect location has no storage and reads zero
  assign rdata  = is_ind ? 8'h00 : mem[phys];                   // [R10] [R11]

  // Stores via the indirect location are dropped
  always_ff @(posedge aclk)
  begin
    if (we && !is_ind)                                          // [R12]
      mem[phys] <= wdata;
  end

endmodule // seq_data_mem

// file: core/seq_pkg.sv
// Constants shared by the sequencing and addressing core
package seq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W   = 11;
  localparam int PTR_W  = 7;
  localparam int DATA_W = 8;
  localparam int RAM_W  = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] PC_RESET      = 11'h7ff;
  localparam logic [1:0]  PAGE_RESET    = 2'h0;
  localparam logic [6:0]  PTR_RESET     = 7'h00;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [1:0]  VAR_RESET     = 2'h2;

  // ----------------------------------------------------------------
  // Variant encodings: program counter width and banking
  // ----------------------------------------------------------------
  localparam logic [1:0]  VAR_PC9_UNBANKED  = 2'h0;
  localparam logic [1:0]  VAR_PC10_UNBANKED = 2'h1;
  localparam logic [1:0]  VAR_PC11_BANKED   = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PAGE_LO_POS   = 9;
  localparam int BIT8_POS      = 8;
  localparam int LOC_W         = 5;
  localparam int ALIAS_POS     = 4;
  localparam logic [4:0] IND_ADDR = 5'h00;
  localparam logic [6:0] PTR_ZERO = 7'h00;
  localparam logic [1:0] UNBANKED_TOP = 2'h3;

  // ----------------------------------------------------------------
  // Register map (byte addresses, each an aligned word)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INSTR  = 8'h04;
  localparam logic [7:0] ADDR_PC     = 8'h08;
  localparam logic [7:0] ADDR_PAGE   = 8'h0c;
  localparam logic [7:0] ADDR_PTR    = 8'h10;
  localparam logic [7:0] ADDR_ACC    = 8'h14;
  localparam logic [7:0] ADDR_STACK1 = 8'h18;
  localparam logic [7:0] ADDR_STACK2 = 8'h1c;
  localparam logic [7:0] ADDR_DATA   = 8'h20;
  localparam logic [7:0] ADDR_RDATA  = 8'h24;

  // ----------------------------------------------------------------
  // Operation codes written to the instruction register, and bus response codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_STEP      = 3'h0;
  localparam logic [2:0] OP_JUMP      = 3'h1;
  localparam logic [2:0] OP_CALL      = 3'h2;
  localparam logic [2:0] OP_RETLIT    = 3'h3;
  localparam logic [2:0] OP_PCL_WRITE = 3'h4;
  localparam logic [2:0] OP_IND_WRITE = 3'h5;
  localparam logic [2:0] OP_IND_READ  = 3'h6;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage

// file: tb/pc_paging_stack_indirect_addr_tb.sv
// Self-checking bench for paging, return stack and indirect addressing
`timescale 1ns/1ps
module pc_paging_stack_indirect_addr_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [10:0] pc_out;
  logic [3:0]  wstrb;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // Clock generation
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  pc_paging_stack_indirect_addr i_dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pc_out(pc_out)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Each half is released at the edge that takes it; ends one edge late so
  // no ready or valid is driven twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok || (awready === 1'b1);
      w_ok = w_ok || (wready === 1'b1);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(d, e);
  endtask

  task automatic ex(input logic [2:0] op, input logic [10:0] v);
    wr(seq_pkg::ADDR_INSTR, {5'h00, op, 13'h0000, v});
  endtask

  task automatic ind_wr(input logic [6:0] p, input logic [7:0] v);
    wr(seq_pkg::ADDR_PTR, {25'h0, p});
    wr(seq_pkg::ADDR_DATA, {24'h0, v});
    ex(seq_pkg::OP_IND_WRITE, 11'h000);
  endtask

  task automatic ind_rd(input logic [6:0] p, input logic [7:0] e);
    wr(seq_pkg::ADDR_PTR, {25'h0, p});
    ex(seq_pkg::OP_IND_READ, 11'h000);
    rc(seq_pkg::ADDR_RDATA, {24'h0, e});
  endtask

  // Hang guard, eight thousand cycles is far beyond the sequence below
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({21'h0, pc_out}, 32'h7ff);
    rc(seq_pkg::ADDR_PAGE, 32'h0);
    ex(seq_pkg::OP_JUMP, 11'h1ff);
    rc(seq_pkg::ADDR_PC, 32'h1ff);
    check({21'h0, pc_out}, 32'h1ff);
    ex(seq_pkg::OP_STEP, 11'h000);
    rc(seq_pkg::ADDR_PC, 32'h200);
    rc(seq_pkg::ADDR_PAGE, 32'h0);
    ex(seq_pkg::OP_JUMP, 11'h7fe);
    rc(seq_pkg::ADDR_PC, 32'h1fe);
    wr(seq_pkg::ADDR_PAGE, 32'h3);
    ex(seq_pkg::OP_JUMP, 11'h0ab);
    rc(seq_pkg::ADDR_PC, 32'h6ab);
    // Three nested calls, the oldest return address falls off
    wr(seq_pkg::ADDR_PAGE, 32'h1);
    ex(seq_pkg::OP_CALL, 11'h1c4);
    rc(seq_pkg::ADDR_PC, 32'h2c4);
    rc(seq_pkg::ADDR_STACK1, 32'h6ac);
    ex(seq_pkg::OP_CALL, 11'h011);
    rc(seq_pkg::ADDR_STACK2, 32'h6ac);
    rc(seq_pkg::ADDR_STACK1, 32'h2c5);
    ex(seq_pkg::OP_CALL, 11'h022);
    rc(seq_pkg::ADDR_STACK2, 32'h2c5);
    ex(seq_pkg::OP_RETLIT, 11'h05a);
    rc(seq_pkg::ADDR_PC, 32'h212);
    rc(seq_pkg::ADDR_ACC, 32'h5a);
    rc(seq_pkg::ADDR_STACK2, 32'h2c5);
    ex(seq_pkg::OP_RETLIT, 11'h0a5);
    ex(seq_pkg::OP_RETLIT, 11'h0a5);
    rc(seq_pkg::ADDR_PC, 32'h2c5);
    rc(seq_pkg::ADDR_ACC, 32'ha5);
    wr(seq_pkg::ADDR_PAGE, 32'h2);
    ex(seq_pkg::OP_PCL_WRITE, 11'h1cd);
    rc(seq_pkg::ADDR_PC, 32'h4cd);
    // Cleared low strobe lane drops the write but still answers okay
    wstrb <= 4'he;
    wr(seq_pkg::ADDR_PAGE, 32'h1);
    wstrb <= 4'hf;
    check({30'h0, r}, {30'h0, seq_pkg::RESP_OKAY});
    rc(seq_pkg::ADDR_PAGE, 32'h2);
    // Indirect access, pointer zero, banks and the shared low half
    ind_wr(7'h08, 8'h10);
    ind_wr(7'h09, 8'h0a);
    ind_rd(7'h08, 8'h10);
    ind_rd(7'h09, 8'h0a);
    ind_wr(7'h00, 8'h77);
    ind_rd(7'h00, 8'h00);
    for (int b = 0; b < 4; b++) ind_wr({b[1:0], 5'h15}, 8'h30 + 8'(b));
    for (int b = 0; b < 4; b++) ind_rd({b[1:0], 5'h15}, 8'h30 + 8'(b));
    ind_wr(7'h65, 8'h5c);
    ind_rd(7'h25, 8'h5c);
    // Unbanked variant reads the top pointer bits as ones
    wr(seq_pkg::ADDR_CTRL, 32'h0);
    wr(seq_pkg::ADDR_PTR, 32'h05);
    rc(seq_pkg::ADDR_PTR, 32'h65);
    // Ten-bit variant wraps its top page back to address zero
    wr(seq_pkg::ADDR_CTRL, 32'h1);
    rc(seq_pkg::ADDR_PTR, 32'h65);
    wr(seq_pkg::ADDR_PAGE, 32'h1);
    ex(seq_pkg::OP_JUMP, 11'h1ff);
    rc(seq_pkg::ADDR_PC, 32'h3ff);
    ex(seq_pkg::OP_STEP, 11'h000);
    rc(seq_pkg::ADDR_PC, 32'h000);
    // Unmapped place answers with an error and zero data
    wr(8'h40, 32'h1);
    check({30'h0, r}, {30'h0, seq_pkg::RESP_SLVERR});
    rc(8'h40, 32'h0);
    check({30'h0, r}, {30'h0, seq_pkg::RESP_SLVERR});
    // Second reset in mid-run restores vector and page zero
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(seq_pkg::ADDR_PC, 32'h7ff);
    rc(seq_pkg::ADDR_PAGE, 32'h0);
    // Stack keeps its words over reset; a bare return takes entry one
    rc(seq_pkg::ADDR_STACK1, 32'h2c5);
    ex(seq_pkg::OP_RETLIT, 11'h000);
    rc(seq_pkg::ADDR_PC, 32'h2c5);
    conclude();
  end
endmodule // pc_paging_stack_indirect_addr_tb

// file: tb/seq_monitor.sv
// Checker watching bus handshakes and program counter loading at the block's ports
`timescale 1ns/1ps
module seq_monitor
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [10:0] pc_out
);
  // ----------------------------------------------------------------
  // Instruction decode seen on the write channels
  // ----------------------------------------------------------------
  // Only a whole word taken at one edge counts, a split write is left alone
  wire       take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                    && s_axi_wstrb[0] && (s_axi_awaddr == seq_pkg::ADDR_INSTR);
  wire [2:0] op   = s_axi_wdata[26:24];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Low nine bits are compared so every variant width is covered
  reset_vector_a: assert property (
    $rose(aresetn) |-> pc_out == seq_pkg::PC_RESET) else $error("pc not at reset vector");
  step_advance_a: assert property (
    take && op == seq_pkg::OP_STEP |=> pc_out[8:0] == $past(pc_out[8:0]) + 9'h001)
    else $error("step did not add one");
  jump_low_a: assert property (
    take && op == seq_pkg::OP_JUMP |=> pc_out[8:0] == $past(s_axi_wdata[8:0]))
    else $error("jump low bits wrong");
  call_clear_a: assert property (
    take && (op == seq_pkg::OP_CALL || op == seq_pkg::OP_PCL_WRITE)
    |=> pc_out[8:0] == {1'b0, $past(s_axi_wdata[7:0])}) else $error("bit eight not cleared");
  pc_cause_a: assert property (
    $past(aresetn) && pc_out != $past(pc_out) |-> $rose(s_axi_bvalid))
    else $error("pc moved without an instruction");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_gate_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  read_cause_a: assert property (
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");

  call_seen_c: cover property (take && op == seq_pkg::OP_CALL);
  ret_seen_c: cover property (take && op == seq_pkg::OP_RETLIT);
  ind_seen_c: cover property (take && op == seq_pkg::OP_IND_READ);
endmodule // seq_monitor

bind pc_paging_stack_indirect_addr seq_monitor i_mon
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pc_out(pc_out)
);
